// ### common/dpw_params.svh
`ifndef DPW_PARAMS_SVH
`define DPW_PARAMS_SVH
// register byte offsets
`define DPW_CTL_OFS 4'h0
`define DPW_STS_OFS 4'h4
`define DPW_CFG_OFS 4'h8
// control word bit positions
`define DPW_CB_OFF1 0
`define DPW_CB_OFF2 1
`define DPW_CB_OFF3 2
`define DPW_CB_RESET 7
`define DPW_CB_JOG1 8
`define DPW_CB_JOG2 9
`define DPW_CB_VALID 10
`define DPW_CB_SLOW 11
`define DPW_CB_CATCH 12
// native pass-through mask: bits 03-07, 10, 13-15
`define DPW_NATIVE_MASK 16'he4f8
// config register fields and reset value
`define DPW_CFG_PROF 0
`define DPW_CFG_MIRROR 1
`define DPW_CFG_RELAY 2
`define DPW_CFG_RST 3'h1
// timing
`define DPW_CLK_KHZ 20000
`define DPW_MIRROR_MS 1
`define DPW_MIRROR_LIMIT_MS 10
`endif

// ### common/dpw_pkg.sv
package dpw_pkg;
  // message profile, encoded as setting 512: 0 bus profile, 1 native
  typedef enum logic {DPW_PROF_BUS, DPW_PROF_NATIVE} dpw_prof_t;
  typedef logic [15:0] dpw_word_t;
endpackage : dpw_pkg

// ### hdl/dpw_core.sv
// Notes on behaviour
// - native status bits 04 and 05 read zero
// - bit 06 shows locked trip
// - bit 07 shows any warning
// - bit 08 shows speed equals reference
// - bit 09 low under local stop/control
// - bit 10 low at frequency limit
// - bit 11 high on start or nonzero frequency
// - bit 13 shows DC voltage out of band
// - bit 14 shows current over limit
// - bit 15 shows thermal limit exceeded
// - mirror profile reports raw input levels
// - mirror inputs at bits 05,12-15
// - mirrored input visible within 10 ms
// - mirror profile needs fieldbus option fitted
// - bus profile decode only when profile 0
// - any of bits 00-02 low ramps stop
// - relay energised at zero after ramp stop
// - bits 00-02 all high permit start
// - bits 03-07,10,13-15 keep native meaning
// - bits 08/09 select bus jog 1/2
// - bit 11 slows, bit 12 catches up
// - status bit 00 needs ready and ON bits
// - status 04/05 invert control 01/02
// - start-disable bit 06 set and cleared
// - control word ignored unless bit 10 set
`include "dpw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dpw_core
  import dpw_pkg::*;
#(
  parameter int MIRROR_CYC = `DPW_MIRROR_MS * `DPW_CLK_KHZ
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ctrl_ready_i,
  input wire logic drive_ready_i,
  input wire logic coast_ok_i,
  input wire logic trip_i,
  input wire logic trip_lock_i,
  input wire logic warn_i,
  input wire logic speed_eq_i,
  input wire logic local_stop_i,
  input wire logic local_sel_i,
  input wire logic freq_at_lim_i,
  input wire logic start_cmd_i,
  input wire logic freq_nz_i,
  input wire logic dc_bad_i,
  input wire logic cur_over_i,
  input wire logic therm_i,
  input wire logic trip_reset_i,
  input wire logic fb_fitted_i,
  input wire logic [4:0] din_i,
  output logic [15:0] cmd_word_o,
  output logic ramp_stop_o,
  output logic start_ok_o,
  output logic jog1_o,
  output logic jog2_o,
  output logic ref_dn_o,
  output logic ref_up_o,
  output logic relay_o,
  output logic [15:0] status_o
);
  localparam int TICK_W = 15;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MIRROR_CYC - 1);
  localparam int LIMIT_CYC = `DPW_MIRROR_LIMIT_MS * `DPW_CLK_KHZ;

  dpw_word_t ctl_q;
  dpw_word_t cmd_q;
  logic [2:0] cfg_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [TICK_W-1:0] tick_q;
  logic [4:0] din_q;
  logic start_dis_q;
  logic cmd_new_q;
  dpw_word_t wr_word;
  dpw_word_t sts_d;
  dpw_prof_t prof;
  logic wr_go;
  logic ctl_we;
  logic cfg_we;
  logic mir_on;
  logic bus_on;
  logic on_all;
  logic tick;

  // write address and data are caught separately, in either order
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid_o;
  assign ctl_we = wr_go && awaddr_q == `DPW_CTL_OFS;
  assign cfg_we = wr_go && awaddr_q == `DPW_CFG_OFS;
  assign wr_word = {wstrb_q[1] ? wdata_q[15:8] : ctl_q[15:8],
                    wstrb_q[0] ? wdata_q[7:0] : ctl_q[7:0]};
  assign prof = dpw_prof_t'(cfg_q[`DPW_CFG_PROF]);
  assign bus_on = prof == DPW_PROF_BUS;
  assign mir_on = cfg_q[`DPW_CFG_MIRROR] && fb_fitted_i;
  assign on_all = cmd_q[`DPW_CB_OFF1] && cmd_q[`DPW_CB_OFF2] && cmd_q[`DPW_CB_OFF3];

  // write channel acceptance
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end
    end
  end

  // ready drops while a beat is held so nothing is overwritten
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end
    else
    begin
      s_axi_awready_o <= !aw_hold_q && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o <= !w_hold_q && !(s_axi_wvalid_i && s_axi_wready_o);
    end
  end

  // write response; unmapped or read-only offsets answer slverr
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'b00;
    end
    else if (wr_go)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (ctl_we || cfg_we) ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready_i)
    begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // raw control word and profile settings
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_q <= 16'h0000;
      cfg_q <= `DPW_CFG_RST;
    end
    else
    begin
      if (ctl_we)
        ctl_q <= wr_word;
      if (cfg_we && wstrb_q[0])
        cfg_q <= wdata_q[2:0];
    end
  end

  // only words flagged valid reach the drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmd_q <= 16'h0000;
    else if (ctl_we && wr_word[`DPW_CB_VALID])
      cmd_q <= wr_word;
  end

  // read channel, one cycle after the address is taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= 2'b00;
    end
    else
    begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= 2'b00;
        case (s_axi_araddr_i)
          `DPW_CTL_OFS: s_axi_rdata_o <= {16'h0000, ctl_q};
          `DPW_STS_OFS: s_axi_rdata_o <= {16'h0000, status_o};
          `DPW_CFG_OFS: s_axi_rdata_o <= {29'h0, cfg_q};
          default:
          begin
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // 1 ms sampling tick keeps the mirror lag far inside its bound
  assign tick = tick_q == TICK_LAST;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      tick_q <= '0;
    else
      tick_q <= tick_q + 1'b1;
  end

  // raw input levels, not their assigned functions
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      din_q <= 5'h00;
    else if (tick)
      din_q <= din_i;
  end

  // start-disable: raised on trip reset, off2/off3, power-up
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_dis_q <= 1'b1;
      cmd_new_q <= 1'b0;
    end
    else
    begin
      // clear only on a fresh word, so a held off1 word cannot undo a trip reset
      cmd_new_q <= ctl_we && wr_word[`DPW_CB_VALID];
      if (trip_reset_i || !cmd_q[`DPW_CB_OFF2] || !cmd_q[`DPW_CB_OFF3])
        start_dis_q <= 1'b1;
      else if (cmd_new_q && !cmd_q[`DPW_CB_OFF1] && cmd_q[`DPW_CB_VALID])
        start_dis_q <= 1'b0;
    end
  end

  // status word assembly
  always_comb
  begin
    sts_d = 16'h0000;
    sts_d[0] = ctrl_ready_i;
    sts_d[1] = drive_ready_i;
    sts_d[2] = coast_ok_i;
    sts_d[3] = trip_i;
    sts_d[5:4] = 2'b00;
    sts_d[6] = trip_lock_i;
    sts_d[7] = warn_i;
    sts_d[8] = speed_eq_i;
    sts_d[9] = !(local_stop_i || local_sel_i);
    sts_d[10] = !freq_at_lim_i;
    sts_d[11] = start_cmd_i || freq_nz_i;
    sts_d[13] = dc_bad_i;
    sts_d[14] = cur_over_i;
    sts_d[15] = therm_i;
    if (mir_on)
    begin
      sts_d[5] = din_q[0];
      sts_d[15:12] = din_q[4:1];
    end
    else if (bus_on)
    begin
      sts_d[0] = ctrl_ready_i && on_all;
      sts_d[4] = !cmd_q[`DPW_CB_OFF2];
      sts_d[5] = !cmd_q[`DPW_CB_OFF3];
      sts_d[6] = start_dis_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_o <= 16'h0000;
    else
      status_o <= sts_d;
  end

  // decoded bus-profile commands; native bits pass through
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_word_o <= 16'h0000;
      ramp_stop_o <= 1'b0;
      start_ok_o <= 1'b0;
      jog1_o <= 1'b0;
      jog2_o <= 1'b0;
      ref_dn_o <= 1'b0;
      ref_up_o <= 1'b0;
    end
    else
    begin
      // outside the bus profile the whole word passes through undecoded and the decoded outputs stay low
      cmd_word_o <= bus_on ? (cmd_q & `DPW_NATIVE_MASK) : cmd_q;
      ramp_stop_o <= bus_on && !on_all;
      start_ok_o <= bus_on && on_all;
      jog1_o <= bus_on && cmd_q[`DPW_CB_JOG1];
      jog2_o <= bus_on && cmd_q[`DPW_CB_JOG2] && !cmd_q[`DPW_CB_JOG1];
      ref_dn_o <= bus_on && cmd_q[`DPW_CB_SLOW];
      ref_up_o <= bus_on && cmd_q[`DPW_CB_CATCH] && !cmd_q[`DPW_CB_SLOW];
    end
  end

  // relay closes at standstill after a ramped stop, opens on restart
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      relay_o <= 1'b0;
    else if (!bus_on || !cfg_q[`DPW_CFG_RELAY] || on_all)
      relay_o <= 1'b0;
    else if (!freq_nz_i)
      relay_o <= 1'b1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_unused_bits: assert property ((!bus_on && !mir_on) |=> status_o[5:4] == 2'b00)
    else $error("native status bits 5:4 not zero");
  chk_trip_lock: assert property (!bus_on |=> status_o[6] == $past(trip_lock_i))
    else $error("trip lock bit wrong");
  chk_warn_bit: assert property (warn_i |=> status_o[7])
    else $error("warning bit missing");
  chk_serial_ok: assert property ((local_stop_i || local_sel_i) |=> !status_o[9])
    else $error("serial bit set under local control");
  chk_running_bit: assert property ((start_cmd_i || freq_nz_i) |=> status_o[11])
    else $error("running bit missing");
  chk_mirror_tick: assert property (int'(tick_q) < LIMIT_CYC)
    else $error("mirror sample older than limit");
  chk_mirror_need: assert property (!fb_fitted_i |-> !mir_on)
    else $error("mirror active without option");
  chk_ramp_stop: assert property ((bus_on && !on_all) |=> ramp_stop_o && !start_ok_o)
    else $error("ramp stop not raised");
  chk_start_ok: assert property ((bus_on && on_all) |=> start_ok_o && !relay_o)
    else $error("start not permitted");
  chk_ref_prio: assert property (!(ref_dn_o && ref_up_o))
    else $error("slow-down and catch-up together");
  chk_ready_gate: assert property ((bus_on && !mir_on && !on_all) |=> !status_o[0])
    else $error("ready shown with off bit low");
  chk_off_invert: assert property ((bus_on && !mir_on) |=> status_o[4] == !$past(cmd_q[1]))
    else $error("off2 status not inverted");
  chk_invalid_drop: assert property ((ctl_we && !wr_word[`DPW_CB_VALID]) |=> $stable(cmd_q))
    else $error("invalid word took effect");
  chk_bresp_hold: assert property ((s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o)
    else $error("write response dropped");

  cov_bus_start: cover property (bus_on && on_all ##1 start_ok_o);
  cov_mirror: cover property (mir_on && tick ##1 din_q != $past(din_q));
  cov_relay: cover property (!relay_o ##1 relay_o);
  cov_start_clr: cover property (start_dis_q ##1 !start_dis_q);
endmodule : dpw_core
`default_nettype wire

// ### test/dpw_master.sv
`timescale 1ns/1ps
`default_nettype none
// bus master standing in for the fieldbus host; one transfer at a time
module dpw_master (
  input wire logic clk_i,
  output logic [3:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [3:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // idle values from time zero
  initial
  begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
    wstrb_o = 4'h3;
  end

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= {16'h0000, d}; // caller sets bit 10 when the word must act
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
    end
    while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask : wr

  // rready held until the answer is sampled
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready_i) arvalid_o <= 1'b0;
    end
    while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
endmodule : dpw_master
`default_nettype wire

// ### test/tb_drive_profile_word_logic.sv
`include "dpw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_drive_profile_word_logic
  import dpw_pkg::*;
();
  localparam int MC = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [16:0] c = '0;
  logic [4:0] din = '0;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic ramp_stop, start_ok, jog1, jog2, ref_dn, ref_up, relay, sd;
  dpw_word_t cmd_word, status, lw, e;
  dpw_word_t tbl [9] = '{16'h0407, 16'h0406, 16'h0405, 16'h0403, 16'h0707, 16'h0607, 16'h1c07,
    16'h1407, 16'h0003};
  logic [4:0] dv [3] = '{5'h15, 5'h0a, 5'h1f};
  int num_errors = 0;
  int num_checks = 0;

  always #25 clk_i = ~clk_i;

  dpw_master u_mst (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  dpw_core #(.MIRROR_CYC(MC)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .ctrl_ready_i(c[0]), .drive_ready_i(c[1]), .coast_ok_i(c[2]),
    .trip_i(c[3]), .trip_lock_i(c[4]), .warn_i(c[5]), .speed_eq_i(c[6]), .local_stop_i(c[7]),
    .local_sel_i(c[8]), .freq_at_lim_i(c[9]), .start_cmd_i(c[10]), .freq_nz_i(c[11]),
    .dc_bad_i(c[12]), .cur_over_i(c[13]), .therm_i(c[14]), .trip_reset_i(c[15]),
    .fb_fitted_i(c[16]), .din_i(din), .cmd_word_o(cmd_word), .ramp_stop_o(ramp_stop),
    .start_ok_o(start_ok), .jog1_o(jog1), .jog2_o(jog2), .ref_dn_o(ref_dn), .ref_up_o(ref_up),
    .relay_o(relay), .status_o(status));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // native status word from the condition vector; 04, 05 and 12 carry nothing
  function automatic dpw_word_t nat(input logic [16:0] v);
    return {v[14], v[13], v[12], 1'b0, v[10] | v[11], !v[9], !(v[7] | v[8]), v[6], v[5], v[4], 2'b00, v[3:0]};
  endfunction : nat

  // ramp_stop, start_ok, jog1, jog2, ref_dn, ref_up; jog1 and slow-down take priority
  function automatic logic [5:0] outs(input dpw_word_t w);
    return {!(&w[2:0]), &w[2:0], w[8], w[9] & !w[8], w[11], w[12] & !w[11]};
  endfunction : outs

  // one control word in bus profile; start-disable tracked here, set wins over clear
  task automatic bus_cmd(input dpw_word_t w);
    u_mst.wr(`DPW_CTL_OFS, w, r);
    if (w[10])
    begin
      lw = w;
      if (!w[1] || !w[2]) sd = 1'b1;
      else if (!w[0]) sd = 1'b0;
    end
    repeat (4) @(posedge clk_i);
    check("cmd outputs", {ramp_stop, start_ok, jog1, jog2, ref_dn, ref_up}, outs(lw));
    check("cmd word", cmd_word, lw & `DPW_NATIVE_MASK);
    e = nat(c);
    e[0] = c[0] & (&lw[2:0]);
    e[4] = !lw[1];
    e[5] = !lw[2];
    e[6] = sd;
    check("bus status", status, e);
  endtask : bus_cmd

  // sized at 20000 cycles, far above the few hundred cycles of traffic
  initial
  begin
    #(50 * 20000);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    sd = 1'b1;
    lw = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    u_mst.rd(`DPW_CFG_OFS, d, r);
    check("cfg reset", d, 32'h1);
    u_mst.rd(4'hc, d, r);
    check("unmapped resp", r, 2'b10);
    check("unmapped data", d, 32'h0);
    u_mst.wr(`DPW_STS_OFS, 16'hffff, r);
    check("status write resp", r, 2'b10);
    // each status condition (bits 0-14) alone, then the word over the bus
    for (int i = 0; i < 15; i++)
    begin
      c <= 17'h1 << i;
      repeat (3) @(posedge clk_i);
      check("native status", status, nat(c));
    end
    u_mst.rd(`DPW_STS_OFS, d, r);
    check("status read", d, {16'h0, nat(c)});
    // native profile: whole word kept, bus decode silent
    u_mst.wr(`DPW_CTL_OFS, 16'h0405, r);
    sd = 1'b1;
    repeat (4) @(posedge clk_i);
    check("native cmd", {cmd_word, ramp_stop, start_ok, jog1, jog2, ref_dn, ref_up}, {16'h0405, 6'h0});
    u_mst.wr(`DPW_CFG_OFS, 16'h0000, r);
    c <= 17'h1;
    foreach (tbl[k]) bus_cmd(tbl[k]);
    u_mst.rd(`DPW_CTL_OFS, d, r);
    check("ctl readback", d, {16'h0, tbl[8]});
    // trip reset raises start-disable again
    bus_cmd(16'h0406);
    c <= 17'h8001;
    @(posedge clk_i);
    c <= 17'h1;
    repeat (3) @(posedge clk_i);
    check("start disable", status[6], 1'b1);
    sd = 1'b1;
    // relay after ramp stop at zero frequency; motor still turning when the function is enabled
    c <= 17'h801;
    u_mst.wr(`DPW_CFG_OFS, 16'h0004, r);
    bus_cmd(16'h0406);
    check("relay running", relay, 1'b0);
    c <= 17'h1;
    repeat (4) @(posedge clk_i);
    check("relay at zero", relay, 1'b1);
    bus_cmd(16'h0407);
    check("relay on start", relay, 1'b0);
    // mirroring, first without the option fitted
    u_mst.wr(`DPW_CFG_OFS, 16'h0003, r);
    din <= 5'h15;
    c <= 17'h10;
    repeat (2 * MC + 4) @(posedge clk_i);
    check("mirror unfitted", status, nat(c));
    foreach (dv[k])
    begin
      c <= 17'h10010;
      din <= dv[k];
      repeat (2 * MC + 4) @(posedge clk_i);
      e = nat(c);
      e[5] = din[0];
      e[15:12] = din[4:1];
      check("mirror status", status, e);
    end
    end_of_test();
  end
endmodule : tb_drive_profile_word_logic
`default_nettype wire
